// ### rsu_pkg.sv
// Package for the remote upgrade status and reconfiguration block
package rsu_pkg;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CUR_WORD0 = 8'h00;
  localparam logic [7:0] ADDR_CUR_WORD1 = 8'h04;
  localparam logic [7:0] ADDR_PREV_ONE  = 8'h08;
  localparam logic [7:0] ADDR_PREV_TWO  = 8'h0c;
  localparam logic [7:0] ADDR_UPDATE    = 8'h10;
  localparam logic [7:0] ADDR_CONTROL   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;
  localparam logic [7:0] ADDR_CAPTURE   = 8'h20;
  localparam logic [7:0] ADDR_SHIFT     = 8'h24;

  // Control and update register layout
  localparam int CTL_W         = 39;
  localparam int CTL_TIMER_LSB = 0;
  localparam int CTL_TIMER_W   = 12;
  localparam int CTL_ADDR_LSB  = 12;
  localparam int CTL_ADDR_W    = 22;
  localparam int CTL_WD_EN     = 35;
  localparam int CTL_OSC_INT   = 36;
  localparam int CTL_EARLY     = 37;

  // Status word fields
  localparam int ST_STATE_LSB  = 30;
  localparam int ST_WD_EN      = 29;
  localparam int PREV_STATE_LSB = 24;
  localparam int CAUSE_EXT_RESET = 30;
  localparam int CAUSE_CRC       = 29;
  localparam int CAUSE_PIN_ERR   = 28;
  localparam int CAUSE_WATCHDOG  = 27;
  localparam int CAUSE_CORE      = 26;
  // Fixed tail below the 12 programmable timer bits
  localparam logic [16:0] WD_TAIL = 17'h00008;

  // Marker shifted out for an invalid previous-state capture
  localparam logic [31:0] INVALID_CAPTURE = 32'hffff_ffff;

  // Capture selections
  localparam logic [1:0] CAP_CURRENT = 2'h0;
  localparam logic [1:0] CAP_PREV1   = 2'h1;
  localparam logic [1:0] CAP_PREV2   = 2'h2;

  // Timing
  localparam int CLK_MHZ          = 250;
  localparam int CORE_REQ_MIN_NS  = 250;
  localparam int CORE_REQ_CYCLES  = (CORE_REQ_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RELOAD_NS        = 40;
  localparam int RELOAD_CYCLES    = (RELOAD_NS * CLK_MHZ + 999) / 1000;

  // Master state
  typedef enum logic [1:0] {
    RSU_FACTORY = 2'b00,
    RSU_APP1    = 2'b01,
    RSU_APP2    = 2'b11,
    RSU_RECONF  = 2'b10
  } rsu_state_e;

  // Interrupt bits
  localparam int IRQ_RECONF  = 0;
  localparam int IRQ_CAPTURE = 1;
  localparam int IRQ_W       = 2;

endpackage : rsu_pkg

// ### rsu_core.sv
// Remote upgrade status recording and reconfiguration steering
//
// Behaviour
// - Record the cause of every reconfiguration out of an application image in the status records.
// - Factory current word: state 31:30, zeros 29:24, boot address 23:0.
// - Application word one: state 31:30, watchdog enable 29, timeout 28:0.
// - Application word two: state 31:30, zeros 29:24, boot address 23:0.
// - Keep two previous-state records of identical layout for debugging.
// - One-hot cause bits 30..26: reset, CRC, pin error, watchdog, core.
// - Simultaneous causes: only the highest bit position is flagged.
// - Records hold left state in 25:24, boot address in 23:0.
// - Previous capture before any application entry yields an invalid marker.
// - Update writes from user logic, control writes by machine, factory only.
// - Core request rising in the factory image copies update into control, reconfigures.
// - Any trigger sets control to load factory or application image.
// - Status updated after the error, before factory loading starts.
// - Error triggers clear control; core trigger loads update register from factory only, else clears control.
// - Capture copies status contents into the shift register.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps

module rsu_core
  import rsu_pkg::*;
#(
  parameter int RELOAD_LEN = RELOAD_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger pins from outside the clock domain
  input  wire logic        core_reconfig_request,
  input  wire logic        external_config_reset_n,
  input  wire logic        config_error_pin_n,
  input  wire logic        crc_error,
  input  wire logic        watchdog_expiry,
  // Status to the loader
  output logic             reload_start,
  output logic [1:0]       master_state,
  output logic             irq
);

  // Synchronisers
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1  <= 5'h03;
      sync2  <= 5'h03;
      sync_q <= 5'h03;
    end else begin
      sync1  <= {watchdog_expiry, crc_error, core_reconfig_request,
                 config_error_pin_n, external_config_reset_n};
      sync2  <= sync1;
      sync_q <= sync2;
    end
  end

  // Rising or falling edges of the synchronised levels
  logic ev_ext;
  logic ev_pin;
  logic ev_core;
  logic ev_crc;
  logic ev_wd;
  assign ev_ext  = sync_q[0] & ~sync2[0];
  assign ev_pin  = sync_q[1] & ~sync2[1];
  assign ev_core = ~sync_q[2] & sync2[2];
  assign ev_crc  = ~sync_q[3] & sync2[3];
  assign ev_wd   = ~sync_q[4] & sync2[4];

  // Priority encoder, highest bit first
  function automatic logic [4:0] rsu_one_hot(input logic [4:0] raw);
    logic [4:0] res;
    res = 5'h00;
    if (raw[4]) res = 5'h10;
    else if (raw[3]) res = 5'h08;
    else if (raw[2]) res = 5'h04;
    else if (raw[1]) res = 5'h02;
    else if (raw[0]) res = 5'h01;
    return res;
  endfunction : rsu_one_hot

  logic [4:0] raw_cause;
  logic [4:0] cause;
  logic       trigger;
  assign raw_cause = {ev_ext, ev_crc, ev_pin, ev_wd, ev_core};
  assign cause     = rsu_one_hot(raw_cause);
  assign trigger   = |raw_cause;

  // Registers
  rsu_state_e        state;
  logic [CTL_W-1:0]  update_reg;
  logic [CTL_W-1:0]  control_reg;
  logic [30:0]       prev_one;
  logic [30:0]       prev_two;
  logic              app_seen;
  logic [31:0]       shift_reg;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [15:0]       reload_cnt;

  logic        wr_en;
  logic        rd_en;
  logic        is_factory;
  logic [23:0] boot_addr;
  logic [28:0] wd_value;
  assign wr_en      = psel & penable & pwrite;
  assign rd_en      = psel & penable & ~pwrite;
  assign is_factory = (state == RSU_FACTORY);
  assign boot_addr  = {control_reg[CTL_ADDR_LSB +: CTL_ADDR_W], 2'b00};
  assign wd_value   = {control_reg[CTL_TIMER_LSB +: CTL_TIMER_W], WD_TAIL};

  // Current-state words
  logic [31:0] cur_word0;
  logic [31:0] cur_word1;
  always_comb begin
    if (is_factory) begin
      cur_word0 = {state, 6'h00, boot_addr};
    end else begin
      cur_word0 = {state, control_reg[CTL_WD_EN], wd_value};
    end
    cur_word1 = {state, 6'h00, boot_addr};
  end

  // Master state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= RSU_FACTORY;
    end else begin
      case (state)
        RSU_FACTORY: begin
          if (trigger) state <= RSU_RECONF;
        end
        RSU_APP1, RSU_APP2: begin
          if (trigger) state <= RSU_RECONF;
        end
        RSU_RECONF: begin
          if (reload_cnt == 16'h0001) begin
            state <= (control_reg == '0) ? RSU_FACTORY : RSU_APP1;
          end
        end
        default: state <= RSU_FACTORY;
      endcase
    end
  end

  // Reload hold counter; status is final before the reload pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_cnt <= 16'h0000;
    end else if (state != RSU_RECONF && trigger) begin
      reload_cnt <= 16'(RELOAD_LEN + 1);
    end else if (reload_cnt != 16'h0000) begin
      reload_cnt <= reload_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_start <= 1'b0;
    end else begin
      reload_start <= (state == RSU_RECONF) && (reload_cnt == 16'h0001);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      master_state <= 2'b00;
    end else begin
      master_state <= state;
    end
  end

  // Update register: user writes, factory image only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      update_reg <= '0;
    end else if (wr_en && is_factory && paddr == ADDR_UPDATE) begin
      update_reg <= {update_reg[CTL_W-1:32], pwdata};
    end else if (wr_en && is_factory && paddr == ADDR_CONTROL) begin
      update_reg <= {pwdata[CTL_W-33:0], update_reg[31:0]};
    end
  end

  // Control register: only the state machine writes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control_reg <= '0;
    end else if (state != RSU_RECONF && trigger) begin
      if (cause == 5'h01 && is_factory) begin
        control_reg <= update_reg;
      end else begin
        control_reg <= '0;
      end
    end
  end

  // Previous-state records
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_one <= '0;
      prev_two <= '0;
      app_seen <= 1'b0;
    end else if (state != RSU_RECONF && trigger) begin
      if (!is_factory) begin
        prev_two <= prev_one;
        prev_one <= {cause, state, boot_addr};
      end
    end else if (state == RSU_APP1) begin
      app_seen <= 1'b1;
    end
  end

  // Capture and shift register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= 32'h0000_0000;
    end else if (wr_en && paddr == ADDR_CAPTURE) begin
      case (pwdata[1:0])
        CAP_CURRENT: shift_reg <= is_factory ? cur_word0 : cur_word1;
        CAP_PREV1:   shift_reg <= app_seen ? {1'b0, prev_one} : INVALID_CAPTURE;
        CAP_PREV2:   shift_reg <= app_seen ? {1'b0, prev_two} : INVALID_CAPTURE;
        default:     shift_reg <= cur_word0;
      endcase
    end
  end

  // Interrupt status: set wins over write-one clear
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {wr_en && paddr == ADDR_CAPTURE, reload_start};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= '0;
    end else if (wr_en && paddr == ADDR_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= '0;
    end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // APB: no wait state; pready and read data come from flops
  logic mapped;
  always_comb begin
    if (paddr == ADDR_CUR_WORD0 || paddr == ADDR_CUR_WORD1 ||
        paddr == ADDR_PREV_ONE  || paddr == ADDR_PREV_TWO  ||
        paddr == ADDR_UPDATE    || paddr == ADDR_CONTROL   ||
        paddr == ADDR_IRQ_STAT  || paddr == ADDR_IRQ_MASK  ||
        paddr == ADDR_CAPTURE   || paddr == ADDR_SHIFT) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    if (paddr == ADDR_CUR_WORD0) begin
      rd_mux = cur_word0;
    end else if (paddr == ADDR_CUR_WORD1) begin
      rd_mux = cur_word1;
    end else if (paddr == ADDR_PREV_ONE) begin
      rd_mux = {1'b0, prev_one};
    end else if (paddr == ADDR_PREV_TWO) begin
      rd_mux = {1'b0, prev_two};
    end else if (paddr == ADDR_UPDATE) begin
      rd_mux = update_reg[31:0];
    end else if (paddr == ADDR_CONTROL) begin
      rd_mux = {25'h0, control_reg[CTL_W-1:32]};
    end else if (paddr == ADDR_IRQ_STAT) begin
      rd_mux = {30'h0, irq_stat};
    end else if (paddr == ADDR_IRQ_MASK) begin
      rd_mux = {30'h0, irq_mask};
    end else if (paddr == ADDR_SHIFT) begin
      rd_mux = shift_reg;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : rsu_core

// ### rsu_core_monitor.sv
// Assertion checker for the upgrade status block
`timescale 1ns/1ps
module rsu_core_monitor #(
  parameter int RELOAD_LEN = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Triggers
  input wire logic        core_reconfig_request,
  input wire logic        external_config_reset_n,
  input wire logic        config_error_pin_n,
  input wire logic        crc_error,
  input wire logic        watchdog_expiry,
  // Status
  input wire logic        reload_start,
  input wire logic [1:0]  master_state,
  input wire logic        irq
);
  localparam int RL_LO = RELOAD_LEN;
  localparam int RL_HI = RELOAD_LEN + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ready_wait: assert property (psel && !penable |=> pready)
    else $error("no pready in access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  a_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_core_steer: assert property ($rose(core_reconfig_request) && master_state != 2'b10
    |-> ##[3:4] master_state == 2'b10) else $error("core request not taken");
  a_pin_steer: assert property ($fell(config_error_pin_n) && master_state != 2'b10
    |-> ##[3:4] master_state == 2'b10) else $error("pin error not taken");
  a_reload_time: assert property ($rose(master_state == 2'b10)
    |-> ##[RL_LO:RL_HI] reload_start) else $error("reload late");
  a_reload_state: assert property (reload_start |-> $past(master_state) == 2'b10)
    else $error("reload outside reconfiguration");
  a_state_exit: assert property (reload_start |=> master_state != 2'b10)
    else $error("stuck reconfiguring");
  c_reload: cover property (reload_start);
  c_refused: cover property (pslverr);
  c_core: cover property ($rose(core_reconfig_request));
endmodule : rsu_core_monitor

bind rsu_core rsu_core_monitor #(.RELOAD_LEN(RELOAD_LEN)) mon_u (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_reconfig_request(core_reconfig_request),
  .external_config_reset_n(external_config_reset_n),
  .config_error_pin_n(config_error_pin_n), .crc_error(crc_error),
  .watchdog_expiry(watchdog_expiry), .reload_start(reload_start),
  .master_state(master_state), .irq(irq));

// ### rsu_user_model.sv
// Fabric user logic driving the trigger pins
`timescale 1ns/1ps
module rsu_user_model
  import rsu_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Bench command, bits ext, crc, pin, watchdog, core
  input  wire logic [4:0] fire,
  // Trigger pins
  output logic            core_reconfig_request,
  output logic            external_config_reset_n,
  output logic            config_error_pin_n,
  output logic            crc_error,
  output logic            watchdog_expiry
);
  logic [4:0] act;
  int         cnt;
  // Every pin held the full minimum, so one counter serves all
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act <= 5'h0;
      cnt <= 0;
    end else if (fire != 5'h0) begin
      act <= fire;
      cnt <= CORE_REQ_CYCLES;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else begin
      act <= 5'h0;
    end
  end
  assign core_reconfig_request   = act[0];
  assign watchdog_expiry         = act[1];
  assign config_error_pin_n      = ~act[2];
  assign crc_error               = act[3];
  assign external_config_reset_n = ~act[4];
endmodule : rsu_user_model

// ### testbench.sv
// Self-checking bench for the upgrade status block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
  import rsu_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, exp_v, prev;
  logic [4:0]  fire = 5'h0;
  logic        core_req, ext_n, pin_n, crc, wdx, reload_start, irq, err;
  logic [1:0]  master_state;
  logic [4:0]  masks [5] = '{5'b10010, 5'b01000, 5'b00100, 5'b00010, 5'b00001};
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #2 clk = ~clk;

  rsu_core #(.RELOAD_LEN(6)) dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_reconfig_request(core_req),
    .external_config_reset_n(ext_n), .config_error_pin_n(pin_n), .crc_error(crc),
    .watchdog_expiry(wdx), .reload_start(reload_start), .master_state(master_state),
    .irq(irq));
  rsu_user_model user_u (.clk(clk), .rst_b(rst_b), .fire(fire),
    .core_reconfig_request(core_req), .external_config_reset_n(ext_n),
    .config_error_pin_n(pin_n), .crc_error(crc), .watchdog_expiry(wdx));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No local limit: only the watchdog may end a stalled wait
    do begin @(posedge clk); end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, r)
  endtask : rd

  // Waits out the whole pin hold so the next trigger sees a fresh edge
  task automatic fire_wait(input logic [4:0] m);
    int n;
    fire <= m;
    @(posedge clk);
    fire <= 5'h0;
    n = 0;
    while (reload_start !== 1'b1 && n < 300) begin @(posedge clk); n++; end
    `CHK("reload", 1'b1, reload_start)
    repeat (80) @(posedge clk);
  endtask : fire_wait

  task automatic final_report();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(ADDR_CUR_WORD0, 32'h0, "factory word");
    apb(1'b1, ADDR_CAPTURE, {30'h0, CAP_PREV1});
    rd(ADDR_SHIFT, INVALID_CAPTURE, "early capture");
    `CHK("irq masked", 1'b0, irq)
    rd(8'h28, 32'h0, "unmapped read");
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    prev = 32'h0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_UPDATE, 32'h00401003);
      apb(1'b1, ADDR_CONTROL, 32'h38);
      fire_wait(5'b00001);
      `CHK("app state", 2'b01, master_state)
      rd(ADDR_CONTROL, 32'h38, "control copy");
      rd(ADDR_CUR_WORD0, 32'h60060008, "app word one");
      rd(ADDR_CUR_WORD1, 32'h40001004, "app word two");
      `CHK("irq set", 1'b1, irq)
      apb(1'b1, ADDR_IRQ_STAT, 32'h1);
      apb(1'b1, ADDR_UPDATE, 32'hffffffff);
      rd(ADDR_UPDATE, 32'h00401003, "update locked");
      `CHK("irq clear", 1'b0, irq)
      // First round fires two causes at once
      fire_wait(masks[i]);
      exp_v = (32'h1 << (30 - i)) | 32'h01001004;
      rd(ADDR_PREV_ONE, exp_v, "record one");
      if (i > 0) rd(ADDR_PREV_TWO, prev, "record two");
      rd(ADDR_CONTROL, 32'h0, "control cleared");
      `CHK("factory state", 2'b00, master_state)
      prev = exp_v;
    end
    apb(1'b1, ADDR_CAPTURE, {30'h0, CAP_PREV1});
    rd(ADDR_SHIFT, prev, "capture one");
    apb(1'b1, ADDR_IRQ_MASK, 32'h2);
    apb(1'b1, ADDR_CAPTURE, {30'h0, CAP_PREV2});
    rd(ADDR_SHIFT, 32'h09001004, "capture two");
    `CHK("irq capture", 1'b1, irq)
    apb(1'b1, ADDR_CAPTURE, {30'h0, CAP_CURRENT});
    rd(ADDR_SHIFT, 32'h0, "capture current");
    final_report();
  end
endmodule : testbench
